// *** common/dccd_pkg.sv ***
// Shared constants and types for the dynamic core clock divider.
// Assumes one core clock and an APB master with 32-bit data.
package dccd_pkg;

  // ==========================================================
  // Bus geometry
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned RATIO_W = 6;

  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] CFG_OFFSET   = 12'h000;
  localparam logic [11:0] STRAP_OFFSET = 12'h004;

  // ==========================================================
  // Field positions
  localparam int unsigned CFG_HALF_BIT    = 0;
  localparam int unsigned CFG_QUARTER_BIT = 1;
  localparam int unsigned CFG_RATIO_LSB   = 8;
  localparam int unsigned CFG_MODE_LSB    = 16;
  localparam int unsigned STRAP_VALID_BIT = 8;

  // ==========================================================
  // Reset values and timing counts
  localparam logic [1:0]  CFG_SW_RESET    = 2'h0;
  localparam logic [5:0]  RATIO_RESET     = 6'h00;
  localparam logic [1:0]  STRAP_SETTLE    = 2'h3;
  localparam logic [5:0]  MIN_DIV_RATIO   = 6'h02;
  localparam logic [1:0]  HALF_PERIOD     = 2'h1;
  localparam logic [1:0]  QUARTER_PERIOD  = 2'h3;

  // ==========================================================
  // Ratio modes
  typedef enum logic [1:0] {
    DCCD_FULL    = 2'b00,
    DCCD_HALF    = 2'b01,
    DCCD_QUARTER = 2'b10
  } dccd_mode_type;

  // Requests from pins (already synchronised, active high) and software
  typedef struct packed {
    logic hw_half;
    logic hw_quarter;
    logic sw_half;
    logic sw_quarter;
  } dccd_req_type;

endpackage

// *** src/dccd_sync3.sv ***
// Three-stage synchroniser with agreement filter, one lane per bit.
// Assumes inputs are asynchronous to i_clk; reset value is a constant.
module dccd_sync3 #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk,     // Core clock
  input  wire logic         i_reset_n, // Async reset, active low
  input  wire logic [W-1:0] i_async,   // Raw pin levels
  output logic      [W-1:0] o_level    // Filtered synchronous levels
);

  // ==========================================================
  // Per-bit lanes
  for (genvar g = 0; g < W; g++) begin : g_lane
    logic s1;
    logic s2;
    logic s3;
    logic next_lvl;

    // Only stage two and three are compared; stage one may be metastable
    always_comb begin
      next_lvl = (s2 == s3) ? s3 : o_level[g];
    end

    // Shift chain and filtered level
    always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        s1         <= RST_VAL[g];
        s2         <= RST_VAL[g];
        s3         <= RST_VAL[g];
        o_level[g] <= RST_VAL[g];
      end else begin
        s1         <= i_async[g];
        s2         <= s1;
        s3         <= s2;
        o_level[g] <= next_lvl;
      end
    end
  end

endmodule

// *** src/dccd_ratio_sel.sv ***
// Request arbitration and strap-based support check, purely combinational.
// Assumes strap holds the full-speed multiplier in half steps.
module dccd_ratio_sel
  import dccd_pkg::*;
(
  input  wire dccd_pkg::dccd_req_type  i_req,        // Pin and software requests
  input  wire dccd_pkg::dccd_mode_type i_mode,       // Mode now in effect
  input  wire logic                    i_strap_ok,   // Strap captured
  input  wire logic [5:0]              i_strap,      // Captured strap
  output dccd_pkg::dccd_mode_type      o_next_mode,  // Mode for next cycle
  output logic [5:0]                   o_next_ratio  // Multiplier for next mode
);

  logic          half_ok;
  logic          quarter_ok;
  dccd_mode_type want;

  // ==========================================================
  // Arbitration and support check
  always_comb begin
    // A ratio is usable only if it divides exactly and stays at or above the floor
    half_ok    = (i_strap[0] == 1'b0) && ({1'b0, i_strap[5:1]} >= MIN_DIV_RATIO);
    quarter_ok = (i_strap[1:0] == 2'h0) && ({2'h0, i_strap[5:2]} >= MIN_DIV_RATIO);
    if (i_req.hw_half && i_req.hw_quarter) begin
      want = DCCD_FULL;
    end else if (i_req.hw_half) begin
      want = DCCD_HALF;
    end else if (i_req.hw_quarter) begin
      want = DCCD_QUARTER;
    end else if (i_req.sw_quarter) begin
      want = DCCD_QUARTER;
    end else if (i_req.sw_half) begin
      want = DCCD_HALF;
    end else begin
      want = DCCD_FULL;
    end
    o_next_mode = i_mode;
    case (want)
      DCCD_HALF: begin
        if (half_ok) begin
          o_next_mode = DCCD_HALF;
        end
      end
      DCCD_QUARTER: begin
        if (quarter_ok) begin
          o_next_mode = DCCD_QUARTER;
        end
      end
      default: begin
        o_next_mode = DCCD_FULL;
      end
    endcase
    if (!i_strap_ok) begin
      o_next_mode = DCCD_FULL;
    end
    case (o_next_mode)
      DCCD_HALF:    o_next_ratio = {1'b0, i_strap[5:1]};
      DCCD_QUARTER: o_next_ratio = {2'h0, i_strap[5:2]};
      default:      o_next_ratio = i_strap;
    endcase
  end

endmodule

// *** src/dccd_top.sv ***
// Dynamic core clock divider: APB registers, pin sync, mode and clock enable.
// Assumes one 10 MHz core clock and a strap held stable through reset.
//
// Added by the designer: the APB register port and the address map.
module dccd_top
  import dccd_pkg::*;
(
  input  wire logic                        I_REF_CLK,             // Core clock
  input  wire logic                        I_RESET_N,             // Hard reset, active low
  input  wire logic                        I_PSEL,                // APB select
  input  wire logic                        I_PENABLE,             // APB access phase
  input  wire logic                        I_PWRITE,              // APB write
  input  wire logic [dccd_pkg::ADDR_W-1:0] I_PADDR,               // APB byte address
  input  wire logic [dccd_pkg::DATA_W-1:0] I_PWDATA,              // APB write data
  input  wire logic [3:0]                  I_PSTRB,               // APB byte strobes
  input  wire logic                        I_HALF_SPEED_PIN_N,    // Half request pin
  input  wire logic                        I_QUARTER_SPEED_PIN_N, // Quarter request pin
  input  wire logic [5:0]                  I_CORE_RATIO_STRAP,    // Ratio strap pins
  output logic      [dccd_pkg::DATA_W-1:0] O_PRDATA,              // APB read data
  output logic                             O_PREADY,              // APB ready
  output logic                             O_PSLVERR,             // APB error
  output logic                             O_CORE_CLK_EN,         // Core clock enable
  output logic      [5:0]                  O_CURRENT_RATIO,       // Multiplier in effect
  output logic      [1:0]                  O_DIV_MODE             // Mode in effect
);

  // ==========================================================
  // Declarations
  logic [1:0]    pin_level_n;
  logic [5:0]    strap_sync;
  logic [5:0]    strap;
  logic [5:0]    next_strap;
  logic          strap_ok;
  logic          next_strap_ok;
  logic [2:0]    settle_cnt;
  logic [2:0]    next_settle_cnt;
  logic [1:0]    sw_bits;
  logic [1:0]    next_sw_bits;
  dccd_req_type  req;
  dccd_mode_type mode;
  dccd_mode_type sel_mode;
  dccd_mode_type next_mode;
  logic [5:0]    sel_ratio;
  logic [5:0]    next_ratio;
  logic [1:0]    div_cnt;
  logic [1:0]    next_div_cnt;
  logic          next_clk_en;
  logic          access;
  logic          done;
  logic          hit_cfg;
  logic          hit_strap;
  logic [31:0]   rd_word;
  logic [31:0]   next_prdata;
  logic          next_pready;
  logic          next_pslverr;

  // ==========================================================
  // Pin synchronisers
  // Pins idle high so the reset value means no request
  dccd_sync3 #(
    .W       (2),
    .RST_VAL (2'h3)
  ) u_pin_sync (
    .i_clk     (I_REF_CLK),
    .i_reset_n (I_RESET_N),
    .i_async   ({I_QUARTER_SPEED_PIN_N, I_HALF_SPEED_PIN_N}),
    .o_level   (pin_level_n)
  );

  // Strap also comes from pins; it is captured only after it has settled
  dccd_sync3 #(
    .W       (6),
    .RST_VAL (6'h00)
  ) u_strap_sync (
    .i_clk     (I_REF_CLK),
    .i_reset_n (I_RESET_N),
    .i_async   (I_CORE_RATIO_STRAP),
    .o_level   (strap_sync)
  );

  // ==========================================================
  // Strap capture after reset release
  // A level cannot be loaded under async reset, so it is caught here
  always_comb begin
    next_settle_cnt = settle_cnt;
    next_strap      = strap;
    next_strap_ok   = strap_ok;
    if (!strap_ok) begin
      // Filter output trails the settle count by one edge, so wait one more
      if (settle_cnt == ({1'b0, STRAP_SETTLE} + 3'h1)) begin
        next_strap    = strap_sync;
        next_strap_ok = 1'b1;
      end else begin
        next_settle_cnt = settle_cnt + 3'h1;
      end
    end
  end

  // Strap capture registers
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      settle_cnt <= 3'h0;
      strap      <= 6'h00;
      strap_ok   <= 1'b0;
    end else begin
      settle_cnt <= next_settle_cnt;
      strap      <= next_strap;
      strap_ok   <= next_strap_ok;
    end
  end

  // ==========================================================
  // Request gathering
  // Pins are active low; the synchronised level is inverted once here
  always_comb begin
    req.hw_half    = ~pin_level_n[0];
    req.hw_quarter = ~pin_level_n[1];
    req.sw_half    = sw_bits[CFG_HALF_BIT];
    req.sw_quarter = sw_bits[CFG_QUARTER_BIT];
  end

  // ==========================================================
  // Mode selection
  dccd_ratio_sel u_sel (
    .i_req        (req),
    .i_mode       (mode),
    .i_strap_ok   (strap_ok),
    .i_strap      (strap),
    .o_next_mode  (sel_mode),
    .o_next_ratio (sel_ratio)
  );

  // No idle gap: the new mode is taken at the very next edge
  always_comb begin
    next_mode  = sel_mode;
    next_ratio = sel_ratio;
  end

  // ==========================================================
  // Core clock enable divider
  // Counter restarts on a mode change so the new rate starts at once
  always_comb begin
    if (next_mode != mode) begin
      next_div_cnt = 2'h0;
    end else begin
      next_div_cnt = div_cnt + 2'h1;
    end
    case (next_mode)
      DCCD_HALF: begin
        next_div_cnt = next_div_cnt & HALF_PERIOD;
        next_clk_en  = (next_div_cnt == 2'h0);
      end
      DCCD_QUARTER: begin
        next_div_cnt = next_div_cnt & QUARTER_PERIOD;
        next_clk_en  = (next_div_cnt == 2'h0);
      end
      default: begin
        next_div_cnt = 2'h0;
        next_clk_en  = 1'b1;
      end
    endcase
  end

  // Mode, ratio and enable registers
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      mode            <= DCCD_FULL;
      div_cnt         <= 2'h0;
      O_CORE_CLK_EN   <= 1'b1;
      O_CURRENT_RATIO <= RATIO_RESET;
      O_DIV_MODE      <= DCCD_FULL;
    end else begin
      mode            <= next_mode;
      div_cnt         <= next_div_cnt;
      O_CORE_CLK_EN   <= next_clk_en;
      O_CURRENT_RATIO <= next_ratio;
      O_DIV_MODE      <= next_mode;
    end
  end

  // ==========================================================
  // APB decode
  // One wait state keeps every bus output straight from a flip-flop
  always_comb begin
    access    = I_PSEL && I_PENABLE && !O_PREADY;
    done      = I_PSEL && I_PENABLE && O_PREADY;
    hit_cfg   = (I_PADDR[11:2] == CFG_OFFSET[11:2]);
    hit_strap = (I_PADDR[11:2] == STRAP_OFFSET[11:2]);
  end

  // Read word assembly; unused bits read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_cfg) begin
      rd_word[CFG_HALF_BIT]    = sw_bits[CFG_HALF_BIT];
      rd_word[CFG_QUARTER_BIT] = sw_bits[CFG_QUARTER_BIT];
      rd_word[CFG_RATIO_LSB +: 6] = O_CURRENT_RATIO;
      rd_word[CFG_MODE_LSB +: 2]  = O_DIV_MODE;
    end else if (hit_strap) begin
      rd_word[5:0]             = strap;
      rd_word[STRAP_VALID_BIT] = strap_ok;
    end
  end

  // Bus answer: ready for one cycle, error on unmapped words
  always_comb begin
    next_pready  = access;
    next_pslverr = access && !(hit_cfg || hit_strap);
    next_prdata  = 32'h0000_0000;
    if (access && !I_PWRITE) begin
      next_prdata = rd_word;
    end
  end

  // ==========================================================
  // Software request bits
  // Written only at the edge where the master sees ready
  always_comb begin
    next_sw_bits = sw_bits;
    if (done && I_PWRITE && hit_cfg && I_PSTRB[0]) begin
      next_sw_bits[CFG_HALF_BIT]    = I_PWDATA[CFG_HALF_BIT];
      next_sw_bits[CFG_QUARTER_BIT] = I_PWDATA[CFG_QUARTER_BIT];
    end
  end

  // Bus and software bit registers
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      sw_bits   <= CFG_SW_RESET;
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA  <= 32'h0000_0000;
    end else begin
      sw_bits   <= next_sw_bits;
      O_PREADY  <= next_pready;
      O_PSLVERR <= next_pslverr;
      O_PRDATA  <= next_prdata;
    end
  end

endmodule

// *** testbench/dccd_props.sv ***
// Checker for the divider top: mode, ratio, clock enable, bus answers.
// Assumes the strap only moves while reset is held.
module dccd_props
  import dccd_pkg::*;
(
  input wire logic        I_REF_CLK,             // Core clock
  input wire logic        I_RESET_N,             // Reset, active low
  input wire logic        I_PSEL,                // APB select
  input wire logic        I_PENABLE,             // APB access
  input wire logic        I_PWRITE,              // APB write
  input wire logic [11:0] I_PADDR,               // APB address
  input wire logic [31:0] I_PWDATA,              // APB write data
  input wire logic [3:0]  I_PSTRB,               // APB strobes
  input wire logic        I_HALF_SPEED_PIN_N,    // Half pin
  input wire logic        I_QUARTER_SPEED_PIN_N, // Quarter pin
  input wire logic [5:0]  I_CORE_RATIO_STRAP,    // Strap
  input wire logic        O_PREADY,              // APB ready
  input wire logic        O_PSLVERR,             // APB error
  input wire logic        O_CORE_CLK_EN,         // Clock enable
  input wire logic [5:0]  O_CURRENT_RATIO,       // Ratio in effect
  input wire logic [1:0]  O_DIV_MODE             // Mode in effect
);
  // ==========================================================
  // Helper counters: saturate so they never wrap back to zero
  logic [2:0] rdy_cnt, next_rdy_cnt, idle_cnt, next_idle_cnt;
  logic       rdy, idle, hok, qok;
  always_comb begin
    next_rdy_cnt = (rdy_cnt == 3'h7) ? rdy_cnt : rdy_cnt + 3'h1;
    next_idle_cnt = (idle_cnt == 3'h7) ? idle_cnt : idle_cnt + 3'h1;
    if (!I_HALF_SPEED_PIN_N || !I_QUARTER_SPEED_PIN_N) next_idle_cnt = 3'h0;
  end
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rdy_cnt <= 3'h0;
      idle_cnt <= 3'h0;
    end else begin
      rdy_cnt <= next_rdy_cnt;
      idle_cnt <= next_idle_cnt;
    end
  end
  // Strap is settled well before the counter saturates
  assign rdy = (rdy_cnt == 3'h7);
  assign idle = (idle_cnt == 3'h7);
  assign hok = !I_CORE_RATIO_STRAP[0] && I_CORE_RATIO_STRAP[5:1] >= 5'h02;
  assign qok = I_CORE_RATIO_STRAP[1:0] == 2'h0 && I_CORE_RATIO_STRAP[5:2] >= 4'h2;
  // ==========================================================
  // Sequences and assertions
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);
  sequence half_pin_s; (!I_HALF_SPEED_PIN_N && I_QUARTER_SPEED_PIN_N) [*6]; endsequence
  sequence qtr_pin_s; (I_HALF_SPEED_PIN_N && !I_QUARTER_SPEED_PIN_N) [*6]; endsequence
  sequence both_pin_s; (!I_HALF_SPEED_PIN_N && !I_QUARTER_SPEED_PIN_N) [*6]; endsequence
  sequence cfg_wr_s;
    I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR[11:2] == 10'h0 && I_PSTRB[0] && idle && rdy;
  endsequence
  pin_half_a: assert property (rdy && hok ##0 half_pin_s |-> O_DIV_MODE == 2'b01)
    else $error("half pin did not select half mode");
  pin_quarter_a: assert property (rdy && qok ##0 qtr_pin_s |-> O_DIV_MODE == 2'b10)
    else $error("quarter pin did not select quarter mode");
  both_pins_a: assert property (both_pin_s |-> O_DIV_MODE == 2'b00)
    else $error("both pins low but mode not full");
  sw_full_a: assert property (
    cfg_wr_s ##0 I_PWDATA[1:0] == 2'b00 |-> ##2 O_DIV_MODE == 2'b00)
    else $error("software clear did not return to full");
  sw_half_a: assert property (
    cfg_wr_s ##0 I_PWDATA[1:0] == 2'b01 && hok |-> ##2 O_DIV_MODE == 2'b01)
    else $error("software half not in effect after one cycle");
  sw_quarter_a: assert property (
    cfg_wr_s ##0 I_PWDATA[1] && qok |-> ##2 O_DIV_MODE == 2'b10)
    else $error("software quarter not in effect after one cycle");
  mode_legal_a: assert property (rdy |-> (O_DIV_MODE != 2'b01 || hok) &&
    (O_DIV_MODE != 2'b10 || qok) && O_DIV_MODE != 2'b11)
    else $error("mode not allowed by strap");
  ratio_match_a: assert property (rdy |-> O_CURRENT_RATIO ==
    (O_DIV_MODE == 2'b00 ? I_CORE_RATIO_STRAP :
    O_DIV_MODE == 2'b01 ? {1'b0, I_CORE_RATIO_STRAP[5:1]} : {2'b00, I_CORE_RATIO_STRAP[5:2]}))
    else $error("ratio output does not match mode");
  full_en_a: assert property (O_DIV_MODE == 2'b00 |-> O_CORE_CLK_EN)
    else $error("clock enable low at full speed");
  half_en_a: assert property (
    (O_DIV_MODE == 2'b01) [*2] |-> O_CORE_CLK_EN != $past(O_CORE_CLK_EN))
    else $error("half speed enable not alternating");
  quarter_en_a: assert property (O_DIV_MODE == 2'b10 && O_CORE_CLK_EN |=>
    (!O_CORE_CLK_EN || O_DIV_MODE != 2'b10) [*3] ##1 (O_CORE_CLK_EN || O_DIV_MODE != 2'b10))
    else $error("quarter speed enable not one in four");
  ready_pulse_a: assert property ($rose(I_PENABLE) && I_PSEL |=> O_PREADY ##1 !O_PREADY)
    else $error("ready not a single pulse after access start");
  bus_error_a: assert property (O_PREADY |-> O_PSLVERR == (I_PADDR[11:3] != 9'h0))
    else $error("error flag wrong for address");
endmodule

bind dccd_top dccd_props dccd_props_inst (.*);

// *** testbench/dccd_pin_partner.sv ***
// Model of the system logic that drives the two speed request pins.
// Assumes requests arrive from the bench as active-high levels.
module dccd_pin_partner (
  input  wire logic       i_clk,          // Core clock
  input  wire logic       i_req_half,     // Ask for half speed
  input  wire logic       i_req_quarter,  // Ask for quarter speed
  input  wire logic [1:0] i_lag,          // Extra edges before a change
  output logic            o_half_pin_n,   // Half request pin
  output logic            o_quarter_pin_n // Quarter request pin
);
  logic [1:0] wait_cnt;
  // Pins idle high so nothing is requested before the bench asks
  initial begin
    o_half_pin_n = 1'b1;
    o_quarter_pin_n = 1'b1;
    wait_cnt = 2'h0;
  end
  // Prompt or slow answer; divisions asked for keep the core fast enough
  always @(posedge i_clk) begin
    if ({i_req_half, i_req_quarter} == {!o_half_pin_n, !o_quarter_pin_n}) begin
      wait_cnt <= 2'h0;
    end else if (wait_cnt >= i_lag) begin
      o_half_pin_n <= !i_req_half;
      o_quarter_pin_n <= !i_req_quarter;
      wait_cnt <= 2'h0;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench: APB registers, request pins, strap, reset.
// Assumes the pin partner and the bound checker are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dccd_pkg::*;
  typedef struct {logic [31:0] d; logic e; logic c; logic [1:0] m;} dccd_note_type;
  logic        clk, rst_n, psel, pen, pwr, req_h, req_q, en, hp_n, qp_n, rdy, err;
  logic [11:0] addr;
  logic [31:0] wd, rd;
  logic [3:0]  strb;
  logic [5:0]  strap, ratio;
  logic [1:0]  mode, sw, cur, lag;
  int          err_total, n_checks;
  dccd_note_type notes[$];
  dccd_note_type nt;
  logic [5:0]  straps[3] = '{6'h10, 6'h0A, 6'h05};
  dccd_top dccd_top_inst (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(addr), .I_PWDATA(wd), .I_PSTRB(strb), .I_HALF_SPEED_PIN_N(hp_n),
    .I_QUARTER_SPEED_PIN_N(qp_n), .I_CORE_RATIO_STRAP(strap), .O_PRDATA(rd), .O_PREADY(rdy),
    .O_PSLVERR(err), .O_CORE_CLK_EN(en), .O_CURRENT_RATIO(ratio), .O_DIV_MODE(mode));
  dccd_pin_partner dccd_pin_partner_inst (.i_clk(clk), .i_req_half(req_h), .i_req_quarter(req_q),
    .i_lag(lag), .o_half_pin_n(hp_n), .o_quarter_pin_n(qp_n));
  // ==========================================================
  // Clock, reporting and expected-value model
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [5:0] rat(input logic [1:0] m);
    return m == 2'b00 ? strap : m == 2'b01 ? {1'b0, strap[5:1]} : {2'b00, strap[5:2]};
  endfunction
  function automatic logic [31:0] cfgw();
    return {14'h0, cur, 2'h0, rat(cur), 6'h0, sw};
  endfunction
  // Next mode from pins (low = asserted), software bits and the mode now held
  function automatic logic [1:0] nm(input logic hn, input logic qn);
    logic [1:0] q;
    logic       hok, qok;
    hok = !strap[0] && strap[5:1] >= 5'h02;
    qok = strap[1:0] == 2'h0 && strap[5:2] >= 4'h2;
    if (!hn && !qn) return 2'b00;
    q = !qn ? 2'b10 : !hn ? 2'b01 : sw[1] ? 2'b10 : sw[0] ? 2'b01 : 2'b00;
    if ((q == 2'b01 && !hok) || (q == 2'b10 && !qok)) return cur;
    return q;
  endfunction
  // ==========================================================
  // Bus driver; the watcher below takes each note off at ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [31:0] ed, input logic c, input logic e);
    int n;
    notes.push_back('{ed, e, c, cur});
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    addr <= a;
    wd <= d;
    strb <= s;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      results();
    end
  endtask
  task automatic idle(input int k);
    psel <= 1'b0;
    pen <= 1'b0;
    repeat (k) @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (rdy === 1'b1) begin
      if (notes.size() == 0) cmp(32'h1, 32'h0);
      else begin
        nt = notes.pop_front();
        cmp({31'h0, err}, {31'h0, nt.e});
        if (nt.c) begin
          cmp(rd, nt.d);
          cmp({30'h0, mode}, {30'h0, nt.m});
          cmp({26'h0, ratio}, {26'h0, rat(nt.m)});
        end
      end
    end
  end
  // Software write and readback, then pins asserted and released
  task automatic step(input logic [31:0] d, input logic [3:0] s, input logic [1:0] p);
    apb(1'b1, CFG_OFFSET, d, s, 32'h0, 1'b0, 1'b0);
    if (s[0]) sw = d[1:0];
    cur = nm(1'b1, 1'b1);
    apb(1'b0, CFG_OFFSET, 32'h0, 4'hF, cfgw(), 1'b1, 1'b0);
    lag <= 2'($urandom);
    req_h <= p[0];
    req_q <= p[1];
    idle(12);
    cur = nm(!p[0], !p[1]);
    apb(1'b0, CFG_OFFSET, 32'h0, 4'hF, cfgw(), 1'b1, 1'b0);
    req_h <= 1'b0;
    req_q <= 1'b0;
    idle(12);
    cur = nm(1'b1, 1'b1);
    apb(1'b0, CFG_OFFSET, 32'h0, 4'hF, cfgw(), 1'b1, 1'b0);
    idle(1);
  endtask
  // ==========================================================
  // Main sequence: one hard reset per strap setting
  initial begin
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    addr = 12'h000;
    wd = 32'h0000_0000;
    strb = 4'h0;
    req_h = 1'b0;
    req_q = 1'b0;
    lag = 2'h0;
    err_total = 0;
    n_checks = 0;
    void'($urandom(91));
    foreach (straps[i]) begin
      rst_n <= 1'b0;
      strap <= straps[i];
      sw = 2'h0;
      cur = 2'h0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      idle(8);
      apb(1'b0, STRAP_OFFSET, 32'h0, 4'hF, {23'h0, 1'b1, 2'h0, strap}, 1'b1, 1'b0);
      apb(1'b1, STRAP_OFFSET, $urandom, 4'hF, 32'h0, 1'b0, 1'b0);
      apb(1'b0, STRAP_OFFSET, 32'h0, 4'hF, {23'h0, 1'b1, 2'h0, strap}, 1'b1, 1'b0);
      apb(1'b0, 12'h008, 32'h0, 4'hF, 32'h0, 1'b1, 1'b1);
      apb(1'b1, 12'hFFC, $urandom, 4'hF, 32'h0, 1'b0, 1'b1);
      apb(1'b0, CFG_OFFSET, 32'h0, 4'hF, cfgw(), 1'b1, 1'b0);
      idle(1);
      for (int k = 0; k < 16; k++) step({30'h0, 2'(k)}, 4'hF, 2'(k >> 2));
      step(32'h0000_0003, 4'hE, 2'b00);
      repeat (20) step($urandom, 4'($urandom), 2'($urandom));
      $display("test %0d done strap %h", i, strap);
    end
    results();
  end
endmodule
